// File: rtl/e1fcc_pkg.sv
// package: register map, field layout and constants of the control bank
package e1fcc_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CHAN_W = 5;
  localparam int unsigned NCHAN  = 32;
  localparam int unsigned LOSS_W = 12;

  // register offsets
  localparam logic [ADDR_W-1:0] SIG_STORE_OPT_ADDR  = 8'h1b;
  localparam logic [ADDR_W-1:0] LB_TX_MON_SEL_ADDR  = 8'ha8;
  localparam logic [ADDR_W-1:0] ALGN_RX_MON_SEL_ADDR = 8'haa;

  // writable-bit masks, unassigned bits held at zero
  localparam logic [DATA_W-1:0] SIG_STORE_OPT_MASK  = 8'hef;
  localparam logic [DATA_W-1:0] LB_TX_MON_SEL_MASK  = 8'h9f;
  localparam logic [DATA_W-1:0] ALGN_RX_MON_SEL_MASK = 8'h7f;
  localparam logic [DATA_W-1:0] REG_RESET           = 8'h00;

  // field positions, signaling_store_option_control
  localparam int unsigned TX_STORE_EN_BIT   = 7;
  localparam int unsigned BLK_TBL_FSEL_BIT  = 6;
  localparam int unsigned IDLE_TBL_FSEL_BIT = 5;
  localparam int unsigned RX_REINS_EN_BIT   = 3;
  localparam int unsigned TX_HW_SIG_EN_BIT  = 2;
  localparam int unsigned TX_BP_CLK_SEL_BIT = 1;
  localparam int unsigned LOSS_ALT_BIT      = 0;
  // loopback_tx_monitor_select
  localparam int unsigned REMOTE_LB_BIT     = 7;
  // store_align_rx_monitor_select
  localparam int unsigned RX_ALIGN_BIT      = 6;
  localparam int unsigned TX_ALIGN_BIT      = 5;
  localparam int unsigned CHAN_SEL_MSB      = 4;
  localparam int unsigned CHAN_SEL_LSB      = 0;

  // carrier loss thresholds in consecutive zeros, then counter clear and step values
  localparam logic [LOSS_W-1:0] LOSS_ZEROS_NORMAL = 12'h0ff;
  localparam logic [LOSS_W-1:0] LOSS_ZEROS_ALT    = 12'h800;
  localparam logic [LOSS_W-1:0] LOSS_ZERO         = 12'h000;
  localparam logic [LOSS_W-1:0] LOSS_ONE          = 12'h001;

  typedef enum logic [1:0]
  {
    ALGN_IDLE = 2'b00,
    ALGN_WAIT = 2'b01,
    ALGN_FIRE = 2'b10
  } e1fcc_algn_e;

  typedef struct packed
  {
    logic tx_store_enable;
    logic block_table_function_select;
    logic idle_table_function_select;
    logic rx_reinsertion_enable;
    logic tx_hw_signaling_enable;
    logic tx_backplane_clock_select;
    logic carrier_loss_alternate_criteria;
    logic remote_loopback_enable;
  } e1fcc_ctrl_s;

  typedef struct packed
  {
    logic rx_align;
    logic tx_align;
  } e1fcc_align_s;
endpackage

// File: rtl/e1fcc_top.sv
// common control bank: registers, monitor decode, align, carrier loss
`timescale 1ns/1ns
module e1fcc_top
(
  input  wire logic                         i_clk,
  input  wire logic                         i_rstn,
  input  wire logic [e1fcc_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [e1fcc_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                         i_wr,
  input  wire logic                         i_rd,
  input  wire logic                         i_rx_bp_tick,
  input  wire logic                         i_tx_bp_tick,
  input  wire logic                         i_rx_sep_ok,
  input  wire logic                         i_tx_sep_ok,
  input  wire logic                         i_rx_bit_valid,
  input  wire logic                         i_rx_bit,
  output logic [e1fcc_pkg::DATA_W-1:0]      o_rdata,
  output e1fcc_pkg::e1fcc_ctrl_s            o_ctrl,
  output logic [e1fcc_pkg::NCHAN-1:0]       o_tx_monitor_sel,
  output logic [e1fcc_pkg::NCHAN-1:0]       o_rx_monitor_sel,
  output e1fcc_pkg::e1fcc_align_s           o_align,
  output logic                              o_carrier_loss_alarm
);

  logic [e1fcc_pkg::DATA_W-1:0] sso_q;
  logic [e1fcc_pkg::DATA_W-1:0] ltm_q;
  logic [e1fcc_pkg::DATA_W-1:0] arm_q;
  logic                         wr_sso;
  logic                         wr_ltm;
  logic                         wr_arm;
  logic [e1fcc_pkg::DATA_W-1:0] rd_d;
  logic                         rx_rise;
  logic                         tx_rise;
  e1fcc_pkg::e1fcc_algn_e       rx_st_q;
  e1fcc_pkg::e1fcc_algn_e       tx_st_q;
  logic [e1fcc_pkg::LOSS_W-1:0] zcnt_q;
  logic [e1fcc_pkg::LOSS_W-1:0] zcnt_d;
  logic [e1fcc_pkg::LOSS_W-1:0] thr;

  // one-hot channel decode
  function automatic logic [e1fcc_pkg::NCHAN-1:0] chan_dec
  (
    input logic [e1fcc_pkg::CHAN_W-1:0] sel
  );
    chan_dec = '0;
    chan_dec[sel] = 1'b1;
  endfunction

  // address decode
  always_comb
  begin
    wr_sso = 1'b0;
    wr_ltm = 1'b0;
    wr_arm = 1'b0;
    if (i_addr == e1fcc_pkg::SIG_STORE_OPT_ADDR)
    begin
      wr_sso = i_wr;
    end
    else if (i_addr == e1fcc_pkg::LB_TX_MON_SEL_ADDR)
    begin
      wr_ltm = i_wr;
    end
    else if (i_addr == e1fcc_pkg::ALGN_RX_MON_SEL_ADDR)
    begin
      wr_arm = i_wr;
    end
  end

  // register storage, unassigned bits forced to zero
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      sso_q <= e1fcc_pkg::REG_RESET;
      ltm_q <= e1fcc_pkg::REG_RESET;
      arm_q <= e1fcc_pkg::REG_RESET;
    end
    else
    begin
      if (wr_sso)
      begin
        sso_q <= i_wdata & e1fcc_pkg::SIG_STORE_OPT_MASK;
      end
      if (wr_ltm)
      begin
        ltm_q <= i_wdata & e1fcc_pkg::LB_TX_MON_SEL_MASK;
      end
      if (wr_arm)
      begin
        arm_q <= i_wdata & e1fcc_pkg::ALGN_RX_MON_SEL_MASK;
      end
    end
  end

  // read mux, unmapped reads zero
  always_comb
  begin
    rd_d = e1fcc_pkg::REG_RESET;
    if (i_addr == e1fcc_pkg::SIG_STORE_OPT_ADDR)
    begin
      rd_d = sso_q;
    end
    else if (i_addr == e1fcc_pkg::LB_TX_MON_SEL_ADDR)
    begin
      rd_d = ltm_q;
    end
    else if (i_addr == e1fcc_pkg::ALGN_RX_MON_SEL_ADDR)
    begin
      rd_d = arm_q;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      o_rdata <= e1fcc_pkg::REG_RESET;
    end
    else if (i_rd)
    begin
      o_rdata <= rd_d;
    end
  end

  // control outputs, registered from write data
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      o_ctrl <= '0;
    end
    else
    begin
      if (wr_sso)
      begin
        o_ctrl.tx_store_enable <=
          i_wdata[e1fcc_pkg::TX_STORE_EN_BIT];
        o_ctrl.block_table_function_select <=
          i_wdata[e1fcc_pkg::BLK_TBL_FSEL_BIT];
        o_ctrl.idle_table_function_select <=
          i_wdata[e1fcc_pkg::IDLE_TBL_FSEL_BIT];
        o_ctrl.rx_reinsertion_enable <=
          i_wdata[e1fcc_pkg::RX_REINS_EN_BIT];
        o_ctrl.tx_hw_signaling_enable <=
          i_wdata[e1fcc_pkg::TX_HW_SIG_EN_BIT];
        o_ctrl.tx_backplane_clock_select <=
          i_wdata[e1fcc_pkg::TX_BP_CLK_SEL_BIT];
        o_ctrl.carrier_loss_alternate_criteria <=
          i_wdata[e1fcc_pkg::LOSS_ALT_BIT];
      end
      if (wr_ltm)
      begin
        o_ctrl.remote_loopback_enable <=
          i_wdata[e1fcc_pkg::REMOTE_LB_BIT];
      end
    end
  end

  // channel monitor decode
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      o_tx_monitor_sel <= chan_dec('0);
      o_rx_monitor_sel <= chan_dec('0);
    end
    else
    begin
      if (wr_ltm)
      begin
        o_tx_monitor_sel <= chan_dec(i_wdata[e1fcc_pkg::CHAN_SEL_MSB:
          e1fcc_pkg::CHAN_SEL_LSB]);
      end
      if (wr_arm)
      begin
        o_rx_monitor_sel <= chan_dec(i_wdata[e1fcc_pkg::CHAN_SEL_MSB:
          e1fcc_pkg::CHAN_SEL_LSB]);
      end
    end
  end

  // zero-to-one detection on align bits
  assign rx_rise = wr_arm && i_wdata[e1fcc_pkg::RX_ALIGN_BIT]
                   && !arm_q[e1fcc_pkg::RX_ALIGN_BIT];
  assign tx_rise = wr_arm && i_wdata[e1fcc_pkg::TX_ALIGN_BIT]
                   && !arm_q[e1fcc_pkg::TX_ALIGN_BIT];

  // receive align: wait for backplane tick, fire only if too close
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      rx_st_q <= e1fcc_pkg::ALGN_IDLE;
    end
    else
    begin
      case (rx_st_q)
        e1fcc_pkg::ALGN_IDLE:
        begin
          if (rx_rise)
          begin
            rx_st_q <= e1fcc_pkg::ALGN_WAIT;
          end
        end
        e1fcc_pkg::ALGN_WAIT:
        begin
          if (i_rx_bp_tick && !i_rx_sep_ok)
          begin
            rx_st_q <= e1fcc_pkg::ALGN_FIRE;
          end
          else if (i_rx_bp_tick && !rx_rise)
          begin
            rx_st_q <= e1fcc_pkg::ALGN_IDLE;
          end
        end
        default:
        begin
          rx_st_q <= rx_rise ? e1fcc_pkg::ALGN_WAIT : e1fcc_pkg::ALGN_IDLE;
        end
      endcase
    end
  end

  // transmit align, same scheme on transmit tick
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      tx_st_q <= e1fcc_pkg::ALGN_IDLE;
    end
    else
    begin
      case (tx_st_q)
        e1fcc_pkg::ALGN_IDLE:
        begin
          if (tx_rise)
          begin
            tx_st_q <= e1fcc_pkg::ALGN_WAIT;
          end
        end
        e1fcc_pkg::ALGN_WAIT:
        begin
          if (i_tx_bp_tick && !i_tx_sep_ok)
          begin
            tx_st_q <= e1fcc_pkg::ALGN_FIRE;
          end
          else if (i_tx_bp_tick && !tx_rise)
          begin
            tx_st_q <= e1fcc_pkg::ALGN_IDLE;
          end
        end
        default:
        begin
          tx_st_q <= tx_rise ? e1fcc_pkg::ALGN_WAIT : e1fcc_pkg::ALGN_IDLE;
        end
      endcase
    end
  end

  // one-cycle realign pulses to the stores
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      o_align <= '0;
    end
    else
    begin
      o_align.rx_align <= (rx_st_q == e1fcc_pkg::ALGN_WAIT)
                          && i_rx_bp_tick && !i_rx_sep_ok;
      o_align.tx_align <= (tx_st_q == e1fcc_pkg::ALGN_WAIT)
                          && i_tx_bp_tick && !i_tx_sep_ok;
    end
  end

  // consecutive-zero counter, saturating at the longer threshold
  assign thr = sso_q[e1fcc_pkg::LOSS_ALT_BIT] ? e1fcc_pkg::LOSS_ZEROS_ALT
               : e1fcc_pkg::LOSS_ZEROS_NORMAL;

  always_comb
  begin
    zcnt_d = zcnt_q;
    if (i_rx_bit_valid && i_rx_bit)
    begin
      zcnt_d = e1fcc_pkg::LOSS_ZERO;
    end
    else if (i_rx_bit_valid && zcnt_q != e1fcc_pkg::LOSS_ZEROS_ALT)
    begin
      zcnt_d = zcnt_q + e1fcc_pkg::LOSS_ONE;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      zcnt_q               <= e1fcc_pkg::LOSS_ZERO;
      o_carrier_loss_alarm <= 1'b0;
    end
    else
    begin
      zcnt_q               <= zcnt_d;
      o_carrier_loss_alarm <= (zcnt_d >= thr);
    end
  end

  // assertions
  sequence s_rx_req;
    rx_rise ##1 (rx_st_q == e1fcc_pkg::ALGN_WAIT);
  endsequence

  sequence s_rx_fire;
    i_rx_bp_tick && !i_rx_sep_ok ##1 o_align.rx_align;
  endsequence

  a_store_enable_write: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr_sso |=> o_ctrl.tx_store_enable == $past(i_wdata[7]))
    else $error("store enable not taken from write");

  a_table_selects_write: assert property (@(posedge i_clk)
    disable iff (!i_rstn) wr_sso |=> o_ctrl.block_table_function_select
    == $past(i_wdata[6]) && o_ctrl.idle_table_function_select
    == $past(i_wdata[5]))
    else $error("table selects not taken from write");

  a_remote_loopback: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr_ltm |=> o_ctrl.remote_loopback_enable == $past(i_wdata[7]))
    else $error("remote loopback not taken from write");

  a_tx_monitor_decode: assert property (@(posedge i_clk)
    disable iff (!i_rstn) wr_ltm |=> o_tx_monitor_sel
    == (32'h1 << $past(i_wdata[4:0])))
    else $error("transmit monitor decode wrong");

  a_rx_monitor_decode: assert property (@(posedge i_clk)
    disable iff (!i_rstn) wr_arm |=> o_rx_monitor_sel
    == (32'h1 << $past(i_wdata[4:0])))
    else $error("receive monitor decode wrong");

  a_rx_align_fires: assert property (@(posedge i_clk) disable iff (!i_rstn)
    s_rx_req ##0 (i_rx_bp_tick && !i_rx_sep_ok) |=> o_align.rx_align)
    else $error("receive align did not fire");

  a_rx_align_cause: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_align.rx_align |-> $past(rx_st_q == e1fcc_pkg::ALGN_WAIT)
    && $past(!i_rx_sep_ok))
    else $error("receive align without cause");

  a_tx_align_cause: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_align.tx_align |-> $past(tx_st_q == e1fcc_pkg::ALGN_WAIT)
    && $past(i_tx_bp_tick) && $past(!i_tx_sep_ok))
    else $error("transmit align without cause");

  a_align_single_pulse: assert property (@(posedge i_clk)
    disable iff (!i_rstn) s_rx_fire |=> !o_align.rx_align)
    else $error("receive align longer than one cycle");

  a_loss_declared: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_rx_bit_valid && !i_rx_bit && (zcnt_q == thr - 12'h001)
    && !wr_sso |=> o_carrier_loss_alarm)
    else $error("carrier loss not declared at threshold");

  a_loss_cleared: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_rx_bit_valid && i_rx_bit |=> !o_carrier_loss_alarm)
    else $error("carrier loss held after a one");

  a_reserved_zero: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_rd |=> (o_rdata & ~($past(i_addr) == 8'h1b ? 8'hef :
    $past(i_addr) == 8'ha8 ? 8'h9f : 8'h7f)) == 8'h00)
    else $error("unassigned bit read as one");

endmodule

// File: sim/e1_framer_common_control_test.sv
// self-checking bench for the common control bank
`timescale 1ns/1ns
module e1_framer_common_control_test;
  typedef struct
  {
    int          kind;
    logic [31:0] exp;
    int          due;
  } e1fcc_note_s;

  logic                          i_clk = 1'b0;
  logic                          i_rstn = 1'b0;
  logic [e1fcc_pkg::ADDR_W-1:0]  i_addr = 8'h00;
  logic [e1fcc_pkg::DATA_W-1:0]  i_wdata = 8'h00;
  logic                          i_wr = 1'b0;
  logic                          i_rd = 1'b0;
  logic                          i_rx_bp_tick = 1'b0;
  logic                          i_tx_bp_tick = 1'b0;
  logic                          i_rx_sep_ok = 1'b1;
  logic                          i_tx_sep_ok = 1'b1;
  logic                          i_rx_bit_valid = 1'b0;
  logic                          i_rx_bit = 1'b1;
  logic [e1fcc_pkg::DATA_W-1:0]  o_rdata;
  e1fcc_pkg::e1fcc_ctrl_s        o_ctrl;
  logic [e1fcc_pkg::NCHAN-1:0]   o_tx_monitor_sel;
  logic [e1fcc_pkg::NCHAN-1:0]   o_rx_monitor_sel;
  e1fcc_pkg::e1fcc_align_s       o_align;
  logic                          o_carrier_loss_alarm;
  int                            cyc = 0;
  int                            n_mismatch = 0;
  int                            compares = 0;
  int                            seed = 6905;
  logic [7:0]                    sh_1b = 8'h00;
  logic [7:0]                    sh_a8 = 8'h00;
  logic [7:0]                    sh_aa = 8'h00;
  logic [7:0]                    d;
  e1fcc_note_s                   notes[$];

  e1fcc_top DUT
  (
    .i_clk                (i_clk),
    .i_rstn               (i_rstn),
    .i_addr               (i_addr),
    .i_wdata              (i_wdata),
    .i_wr                 (i_wr),
    .i_rd                 (i_rd),
    .i_rx_bp_tick         (i_rx_bp_tick),
    .i_tx_bp_tick         (i_tx_bp_tick),
    .i_rx_sep_ok          (i_rx_sep_ok),
    .i_tx_sep_ok          (i_tx_sep_ok),
    .i_rx_bit_valid       (i_rx_bit_valid),
    .i_rx_bit             (i_rx_bit),
    .o_rdata              (o_rdata),
    .o_ctrl               (o_ctrl),
    .o_tx_monitor_sel     (o_tx_monitor_sel),
    .o_rx_monitor_sel     (o_rx_monitor_sel),
    .o_align              (o_align),
    .o_carrier_loss_alarm (o_carrier_loss_alarm)
  );

  always #10 i_clk = ~i_clk;

  task automatic summarize;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // cycle count and hang limit
  always @(posedge i_clk)
  begin
    cyc = cyc + 1;
    if (cyc >= 20000)
    begin
      n_mismatch++;
      summarize();
    end
  end

  function automatic logic [31:0] pick(input int kind);
    case (kind)
      0:       pick = {24'h000000, o_rdata};
      1:       pick = {24'h000000, o_ctrl};
      2:       pick = o_tx_monitor_sel;
      3:       pick = o_rx_monitor_sel;
      4:       pick = {30'h00000000, o_align};
      default: pick = {31'h00000000, o_carrier_loss_alarm};
    endcase
  endfunction

  // watcher: takes each note, oldest first, once its result is due
  always @(posedge i_clk)
  begin
    e1fcc_note_s n;
    logic [31:0] got;
    #1;
    while (notes.size() > 0 && notes[0].due <= cyc)
    begin
      n = notes.pop_front();
      got = pick(n.kind);
      compares++;
      if (got !== n.exp)
      begin
        n_mismatch++;
        $display("wrong value at %0t: kind %0d got %h want %h",
                 $time, n.kind, got, n.exp);
      end
    end
  end

  task automatic step;
    @(posedge i_clk);
    #2;
  endtask

  task automatic expect_next(input int kind, input logic [31:0] exp);
    e1fcc_note_s n;
    n.kind = kind;
    n.exp = exp;
    n.due = cyc + 1;
    notes.push_back(n);
  endtask

  task automatic expect_regs;
    expect_next(1, {24'h0, sh_1b[7:5], sh_1b[3:0], sh_a8[7]});
    expect_next(2, 32'h00000001 << sh_a8[4:0]);
    expect_next(3, 32'h00000001 << sh_aa[4:0]);
  endtask

  task automatic do_reset;
    i_rstn = 1'b0;
    repeat (16) step();
    i_rstn = 1'b1;
    sh_1b = 8'h00;
    sh_a8 = 8'h00;
    sh_aa = 8'h00;
    expect_regs();
    expect_next(0, 32'h0);
    expect_next(4, 32'h0);
    expect_next(5, 32'h0);
    step();
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    i_addr = a;
    i_wdata = v;
    i_wr = 1'b1;
    if (a == e1fcc_pkg::SIG_STORE_OPT_ADDR)
      sh_1b = v & 8'hef;
    if (a == e1fcc_pkg::LB_TX_MON_SEL_ADDR)
      sh_a8 = v & 8'h9f;
    if (a == e1fcc_pkg::ALGN_RX_MON_SEL_ADDR)
      sh_aa = v & 8'h7f;
    expect_regs();
    step();
    i_wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    logic [7:0] e;
    e = 8'h00;
    if (a == e1fcc_pkg::SIG_STORE_OPT_ADDR)
      e = sh_1b;
    if (a == e1fcc_pkg::LB_TX_MON_SEL_ADDR)
      e = sh_a8;
    if (a == e1fcc_pkg::ALGN_RX_MON_SEL_ADDR)
      e = sh_aa;
    i_addr = a;
    i_rd = 1'b1;
    expect_next(0, {24'h0, e});
    step();
    i_rd = 1'b0;
  endtask

  // one backplane tick, then the pulse and its end
  task automatic tick(input logic rx, input logic tx, input logic okr,
                      input logic okt, input logic [1:0] e);
    i_rx_bp_tick = rx;
    i_tx_bp_tick = tx;
    i_rx_sep_ok = okr;
    i_tx_sep_ok = okt;
    expect_next(4, {30'h0, e});
    step();
    i_rx_bp_tick = 1'b0;
    i_tx_bp_tick = 1'b0;
    expect_next(4, 32'h0);
    step();
  endtask

  // run of zeros: clear one short of the count, set at the count
  task automatic zeros(input int n);
    i_rx_bit_valid = 1'b1;
    i_rx_bit = 1'b0;
    repeat (n - 2) step();
    expect_next(5, 32'h0);
    step();
    step();
    i_rx_bit_valid = 1'b0;
    expect_next(5, 32'h1);
    step();
    i_rx_bit_valid = 1'b1;
    i_rx_bit = 1'b1;
    step();
    i_rx_bit_valid = 1'b0;
    step();
    expect_next(5, 32'h0);
    step();
  endtask

  initial
  begin
    step();
    do_reset();
    // boundary channels, reserved bits, then random values
    wr_reg(e1fcc_pkg::LB_TX_MON_SEL_ADDR, 8'hff);
    wr_reg(e1fcc_pkg::ALGN_RX_MON_SEL_ADDR, 8'h9f);
    wr_reg(e1fcc_pkg::SIG_STORE_OPT_ADDR, 8'hff);
    rd_reg(e1fcc_pkg::SIG_STORE_OPT_ADDR);
    rd_reg(e1fcc_pkg::LB_TX_MON_SEL_ADDR);
    rd_reg(e1fcc_pkg::ALGN_RX_MON_SEL_ADDR);
    repeat (12)
    begin
      d = 8'($random(seed));
      wr_reg(e1fcc_pkg::SIG_STORE_OPT_ADDR, d);
      d = 8'($random(seed));
      wr_reg(e1fcc_pkg::LB_TX_MON_SEL_ADDR, d);
      d = 8'($random(seed));
      wr_reg(e1fcc_pkg::ALGN_RX_MON_SEL_ADDR, d & 8'h9f);
      rd_reg(e1fcc_pkg::SIG_STORE_OPT_ADDR);
      rd_reg(e1fcc_pkg::ALGN_RX_MON_SEL_ADDR);
      rd_reg(e1fcc_pkg::LB_TX_MON_SEL_ADDR);
    end
    wr_reg(8'h1c, 8'hff);
    rd_reg(8'h1c);
    rd_reg(8'hab);
    rd_reg(e1fcc_pkg::SIG_STORE_OPT_ADDR);
    // align requests
    wr_reg(e1fcc_pkg::ALGN_RX_MON_SEL_ADDR, 8'h00);
    wr_reg(e1fcc_pkg::ALGN_RX_MON_SEL_ADDR, 8'h40);
    tick(1'b1, 1'b0, 1'b0, 1'b0, 2'b10);
    wr_reg(e1fcc_pkg::ALGN_RX_MON_SEL_ADDR, 8'h40);
    tick(1'b1, 1'b0, 1'b0, 1'b0, 2'b00);
    wr_reg(e1fcc_pkg::ALGN_RX_MON_SEL_ADDR, 8'h20);
    tick(1'b1, 1'b1, 1'b1, 1'b1, 2'b00);
    tick(1'b1, 1'b1, 1'b0, 1'b0, 2'b00);
    wr_reg(e1fcc_pkg::ALGN_RX_MON_SEL_ADDR, 8'h00);
    wr_reg(e1fcc_pkg::ALGN_RX_MON_SEL_ADDR, 8'h7f);
    tick(1'b0, 1'b0, 1'b0, 1'b0, 2'b00);
    tick(1'b1, 1'b1, 1'b0, 1'b0, 2'b11);
    // carrier loss, both criteria
    wr_reg(e1fcc_pkg::SIG_STORE_OPT_ADDR, 8'h00);
    zeros(255);
    wr_reg(e1fcc_pkg::SIG_STORE_OPT_ADDR, 8'h01);
    zeros(2048);
    do_reset();
    rd_reg(e1fcc_pkg::SIG_STORE_OPT_ADDR);
    repeat (3) step();
    summarize();
  end
endmodule
